// ===== ilm_pkg.sv
// package: constants, types and helpers of the input link error monitor
package ilm_pkg;
    localparam int unsigned CHANNELS   = 4;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned CRC_W      = 8;
    localparam int unsigned MEM_DEPTH  = 256;
    localparam int unsigned PTR_W      = 8;
    localparam int unsigned TALLY_W    = 16;
    localparam int unsigned VETO_W     = 9;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned REG_W      = 32;
    localparam int unsigned SEL_W      = 3;

    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CLEAR   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CHECK   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TALLY   = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STICKY  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_GLOBAL  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_VETO    = 8'h18;
    localparam logic [ADDR_W-1:0] REG_MEMADDR = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_MEMDATA = 8'h20;

    // control and clear register fields
    localparam int unsigned CTL_PLAYBACK = 0;
    localparam int unsigned CTL_OUT_PB   = 1;
    localparam int unsigned CTL_RO_ALL   = 2;
    localparam int unsigned CLR_BIT      = 0;
    // memory address register fields: word index, then memory select
    localparam int unsigned MA_SEL_LSB   = 8;
    localparam logic [SEL_W-1:0] SEL_OUT_MEM = 3'h4;

    localparam logic [TALLY_W-1:0] TALLY_MAX  = 16'hffff;
    localparam logic [TALLY_W-1:0] TALLY_ONE  = 16'h0001;
    localparam logic [VETO_W-1:0]  VETO_RESET = 9'h000;
    localparam logic [REG_W-1:0]   RD_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CRC_W-1:0]  crc;
    } ilm_link_word_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } ilm_reg_req_type;

    // serial crc over the payload, msb first
    function automatic logic [CRC_W-1:0] crc_of(input logic [DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (c[CRC_W-1] ^ d[i]) begin
                c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[CRC_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction
endpackage

// ===== ilm_monitor.sv
// input link error monitor with playback memories
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps

// What this block does
// - crc checked on every parallel input word
// - errored words zeroed on real-time path
// - errored words go raw to readout
// - check result is or of channel errors
// - tally steps once per errored cycle
// - per-channel sticky flag until cleared
// - global flag is or of sticky flags
// - all error state readable by registers
// - one clear command clears all error state
// - check result and tally join readout
// - no dedicated external error output
// - persistent error readout is pre-scaled
// - playback replaces live inputs with memories
// - input memories mandatory, output memories optional
// - output playback overrides computed output
// - playback applies to all channels together
// - mode and memory writes via registers
// - 256-word memories stepped cyclically
// - error-free readout needs explicit enable
module ilm_monitor (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    // deserialised links, one word per bunch crossing
    input  wire ilm_pkg::ilm_link_word_type    link_i [ilm_pkg::CHANNELS],
    input  wire logic                          link_valid_i,
    // result computed by the feature extraction
    input  wire logic [ilm_pkg::DATA_W-1:0]    feat_result_i,
    // register port
    input  wire ilm_pkg::ilm_reg_req_type      reg_req_i,
    output logic [ilm_pkg::REG_W-1:0]          reg_rdata_o,
    // real-time path into feature extraction
    output logic [ilm_pkg::DATA_W-1:0]         rt_data_o [ilm_pkg::CHANNELS],
    output logic                               rt_valid_o,
    // real-time output
    output logic [ilm_pkg::DATA_W-1:0]         rt_out_o,
    // readout path
    output logic [ilm_pkg::DATA_W-1:0]         ro_data_o [ilm_pkg::CHANNELS],
    output logic [ilm_pkg::CHANNELS-1:0]       ro_sel_o,
    output logic                               ro_valid_o,
    output logic                               ro_check_o,
    output logic [ilm_pkg::TALLY_W-1:0]        ro_tally_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                          playback;
    logic                          out_playback;
    logic                          ro_all;
    logic [ilm_pkg::VETO_W-1:0]    veto_period;
    logic [ilm_pkg::PTR_W-1:0]     mem_addr;
    logic [ilm_pkg::SEL_W-1:0]     mem_sel;
    logic                          clear_cmd;
    logic [ilm_pkg::CHANNELS-1:0]  chan_err;
    logic                          err_any;
    logic                          check_result;
    logic [ilm_pkg::TALLY_W-1:0]   tally;
    logic [ilm_pkg::TALLY_W-1:0]   next_tally;
    logic [ilm_pkg::CHANNELS-1:0]  sticky;
    logic [ilm_pkg::CHANNELS-1:0]  next_sticky;
    logic                          err_global;
    logic [ilm_pkg::PTR_W-1:0]     pb_ptr;
    logic [ilm_pkg::DATA_W-1:0]    pb_word [ilm_pkg::CHANNELS];
    logic [ilm_pkg::CHANNELS-1:0]  veto_busy;
    logic [ilm_pkg::CHANNELS-1:0]  next_sel;
    logic [ilm_pkg::DATA_W-1:0]    out_mem [ilm_pkg::MEM_DEPTH];
    logic                          mem_wr;

    assign mem_wr = reg_req_i.wr && (reg_req_i.addr == ilm_pkg::REG_MEMDATA);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // mode, veto and memory address writes
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            playback     <= 1'b0;
            out_playback <= 1'b0;
            ro_all       <= 1'b0;
            veto_period  <= ilm_pkg::VETO_RESET;
            mem_addr     <= '0;
            mem_sel      <= '0;
        end else if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ilm_pkg::REG_CONTROL: begin
                    playback     <= reg_req_i.wdata[ilm_pkg::CTL_PLAYBACK];
                    out_playback <= reg_req_i.wdata[ilm_pkg::CTL_OUT_PB];
                    ro_all       <= reg_req_i.wdata[ilm_pkg::CTL_RO_ALL];
                end
                ilm_pkg::REG_VETO: begin
                    veto_period <= reg_req_i.wdata[ilm_pkg::VETO_W-1:0];
                end
                ilm_pkg::REG_MEMADDR: begin
                    mem_addr <= reg_req_i.wdata[ilm_pkg::PTR_W-1:0];
                    mem_sel  <= reg_req_i.wdata[ilm_pkg::MA_SEL_LSB +:
                                                ilm_pkg::SEL_W];
                end
                ilm_pkg::REG_MEMDATA: begin
                    mem_addr <= mem_addr + 8'h01;
                end
                default: begin
                end
            endcase
        end
    end

    assign clear_cmd = reg_req_i.wr && (reg_req_i.addr == ilm_pkg::REG_CLEAR)
                       && reg_req_i.wdata[ilm_pkg::CLR_BIT];

    // ------------------------------------------------------------
    // per-channel checking, memories and readout veto
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ilm_pkg::CHANNELS; g++) begin : g_chan
            logic [ilm_pkg::DATA_W-1:0] in_mem [ilm_pkg::MEM_DEPTH];
            logic [ilm_pkg::VETO_W-1:0] veto_cnt;

            assign chan_err[g] = link_valid_i &&
                (ilm_pkg::crc_of(link_i[g].data) != link_i[g].crc);

            always_ff @(posedge clk_i) begin
                if (mem_wr && (mem_sel == ilm_pkg::SEL_W'(g))) begin
                    in_mem[mem_addr] <= reg_req_i.wdata[ilm_pkg::DATA_W-1:0];
                end
            end
            assign pb_word[g] = in_mem[pb_ptr];

            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    veto_cnt <= ilm_pkg::VETO_RESET;
                end else if (next_sel[g]) begin
                    veto_cnt <= veto_period;
                end else if (veto_cnt != ilm_pkg::VETO_RESET) begin
                    veto_cnt <= veto_cnt - 9'h001;
                end
            end
            assign veto_busy[g] = (veto_cnt != ilm_pkg::VETO_RESET);

            assign next_sel[g] = link_valid_i && !playback && !veto_busy[g]
                                 && (chan_err[g] || ro_all);

            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    rt_data_o[g] <= '0;
                end else if (playback) begin
                    rt_data_o[g] <= pb_word[g];
                end else if (chan_err[g]) begin
                    rt_data_o[g] <= '0;
                end else begin
                    rt_data_o[g] <= link_i[g].data;
                end
            end

            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ro_data_o[g] <= '0;
                end else begin
                    ro_data_o[g] <= link_i[g].data;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // playback stepping and output memory
    // ------------------------------------------------------------
    // cyclic 256-word pointer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pb_ptr <= '0;
        end else if (!playback) begin
            pb_ptr <= '0;
        end else begin
            pb_ptr <= pb_ptr + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_wr && (mem_sel == ilm_pkg::SEL_OUT_MEM)) begin
            out_mem[mem_addr] <= reg_req_i.wdata[ilm_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rt_out_o <= '0;
        end else if (playback && out_playback) begin
            rt_out_o <= out_mem[pb_ptr];
        end else begin
            rt_out_o <= feat_result_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rt_valid_o <= 1'b0;
        end else begin
            rt_valid_o <= link_valid_i || playback;
        end
    end

    // ------------------------------------------------------------
    // error state
    // ------------------------------------------------------------
    // or of all channel checks
    assign err_any = |chan_err;

    // tally: step, saturate, error beats clear
    always_comb begin
        if (clear_cmd) begin
            next_tally = err_any ? ilm_pkg::TALLY_ONE : '0;
        end else if (err_any && (tally != ilm_pkg::TALLY_MAX)) begin
            next_tally = tally + ilm_pkg::TALLY_ONE;
        end else begin
            next_tally = tally;
        end
    end

    // sticky flags, set wins over clear
    assign next_sticky = (clear_cmd ? '0 : sticky) | chan_err;

    // check result, tally, flags and global
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            check_result <= 1'b0;
            tally        <= '0;
            sticky       <= '0;
            err_global   <= 1'b0;
        end else begin
            check_result <= err_any;
            tally        <= next_tally;
            sticky       <= next_sticky;
            err_global   <= |next_sticky;
        end
    end

    // check result and tally beside readout data
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ro_sel_o   <= '0;
            ro_valid_o <= 1'b0;
            ro_check_o <= 1'b0;
            ro_tally_o <= '0;
        end else begin
            ro_sel_o   <= next_sel;
            ro_valid_o <= link_valid_i && !playback;
            ro_check_o <= err_any;
            ro_tally_o <= next_tally;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // error state readable; no separate error pin
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ilm_pkg::REG_CONTROL:
                    reg_rdata_o <= {29'h0, ro_all, out_playback, playback};
                ilm_pkg::REG_CHECK:   reg_rdata_o <= {31'h0, check_result};
                ilm_pkg::REG_TALLY:   reg_rdata_o <= {16'h0, tally};
                ilm_pkg::REG_STICKY:  reg_rdata_o <= {28'h0, sticky};
                ilm_pkg::REG_GLOBAL:  reg_rdata_o <= {31'h0, err_global};
                ilm_pkg::REG_VETO:    reg_rdata_o <= {23'h0, veto_period};
                ilm_pkg::REG_MEMADDR:
                    reg_rdata_o <= {21'h0, mem_sel, mem_addr};
                default:              reg_rdata_o <= ilm_pkg::RD_UNMAPPED;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_live_err0;
        link_valid_i && !playback && chan_err[0];
    endsequence

    sequence s_clear_with_err;
        clear_cmd && err_any;
    endsequence

    chk_zero_on_error: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_live_err0 |=> (rt_data_o[0] == '0))
        else $error("errored channel not zeroed");

    chk_readout_raw: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_live_err0 |=> (ro_data_o[0] == $past(link_i[0].data))
                        && (ro_sel_o[0] || $past(veto_busy[0])))
        else $error("readout copy altered");

    chk_tally_step: assert property (
        @(posedge clk_i) disable iff (reset_i)
        err_any && !clear_cmd && (tally != ilm_pkg::TALLY_MAX)
        |=> tally == $past(tally) + ilm_pkg::TALLY_ONE)
        else $error("tally did not step by one");

    chk_tally_saturate: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (tally == ilm_pkg::TALLY_MAX) && !clear_cmd
        |=> tally == ilm_pkg::TALLY_MAX)
        else $error("tally wrapped");

    chk_sticky_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        sticky[0] && !clear_cmd |=> sticky[0])
        else $error("sticky flag lost");

    chk_global_or: assert property (
        @(posedge clk_i) disable iff (reset_i)
        err_global == (|sticky))
        else $error("global flag differs from sticky or");

    chk_clear_err_wins: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_clear_with_err |=> (tally == ilm_pkg::TALLY_ONE)
                             && (sticky == $past(chan_err)))
        else $error("clear beat a new error");

    chk_pb_wrap: assert property (
        @(posedge clk_i) disable iff (reset_i)
        playback && (pb_ptr == 8'hff) ##1 playback |-> pb_ptr == 8'h00)
        else $error("playback pointer did not wrap");

    chk_veto_gap: assert property (
        @(posedge clk_i) disable iff (reset_i)
        next_sel[0] && (veto_period >= 9'h002) |=> !next_sel[0] [*2])
        else $error("readout not pre-scaled");

    chk_out_select: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !(playback && out_playback) |=> rt_out_o == $past(feat_result_i))
        else $error("computed output not forwarded");

    chk_check_or: assert property (
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> check_result == $past(err_any))
        else $error("check result differs from channel or");

    chk_ro_status: assert property (
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> (ro_tally_o == tally) && (ro_check_o == check_result))
        else $error("readout status differs from registers");

    chk_pb_inputs: assert property (
        @(posedge clk_i) disable iff (reset_i)
        playback |=> (ro_sel_o == '0) && (rt_data_o[0] == $past(pb_word[0])))
        else $error("live inputs used in playback");

endmodule // ilm_monitor

// ===== ilm_link_model.sv
// model of the calorimeter links that feed the monitor
`timescale 1ns/10ps
module ilm_link_model (
    // clock
    input  wire logic                         clk_i,
    // crossing request from the bench
    input  wire logic                         send_i,
    input  wire logic [ilm_pkg::DATA_W-1:0]   base_i,
    input  wire logic [ilm_pkg::CHANNELS-1:0] bad_i,
    // link words towards the monitor
    output ilm_pkg::ilm_link_word_type        link_o [ilm_pkg::CHANNELS],
    output logic                              valid_o
);
    // ------------------------------------------------------------
    // crc of the sender
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // one crossing per request
    // ------------------------------------------------------------
    // a bad channel carries a corrupted crc
    // between crossings the words toggle, so a stale good word fails its crc on alternate cycles and a stale bad word on every cycle
    always_ff @(posedge clk_i) begin
        valid_o <= send_i;
        for (int c = 0; c < ilm_pkg::CHANNELS; c++) begin
            if (send_i) begin
                link_o[c].data <= base_i + 16'(c);
                link_o[c].crc  <= crc8(base_i + 16'(c)) ^ {7'h00, bad_i[c]};
            end else begin
                link_o[c] <= ~link_o[c];
            end
        end
    end
endmodule // ilm_link_model

// ===== input_link_error_monitor_playback_tb.sv
// testbench of the input link error monitor
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
        end \
    end
module input_link_error_monitor_playback_tb;
    logic                       clk_i;
    logic                       reset_i;
    logic                       send;
    logic                       lvalid;
    logic [15:0]                base;
    logic [15:0]                feat;
    logic [15:0]                rt_out;
    logic [15:0]                tally;
    logic [15:0]                exp_tally;
    logic [15:0]                w0;
    logic [3:0]                 bad;
    logic [3:0]                 ro_sel;
    logic [31:0]                rdata;
    logic                       rt_valid;
    logic                       ro_valid;
    logic                       ro_check;
    logic [15:0]                rt_data [4];
    logic [15:0]                ro_data [4];
    ilm_pkg::ilm_link_word_type link [4];
    ilm_pkg::ilm_reg_req_type   req;
    int                         bad_count;
    int                         num_checks;

    ilm_link_model model (.clk_i(clk_i), .send_i(send), .base_i(base),
        .bad_i(bad), .link_o(link), .valid_o(lvalid));
    ilm_monitor dut (.clk_i(clk_i), .reset_i(reset_i), .link_i(link),
        .link_valid_i(lvalid), .feat_result_i(feat), .reg_req_i(req),
        .reg_rdata_o(rdata), .rt_data_o(rt_data), .rt_valid_o(rt_valid),
        .rt_out_o(rt_out), .ro_data_o(ro_data), .ro_sel_o(ro_sel),
        .ro_valid_o(ro_valid), .ro_check_o(ro_check),
        .ro_tally_o(tally));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // register access and crossings
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        `CHK(n, e, rdata)
    endtask

    task automatic xing(input logic [15:0] b, input logic [3:0] m,
                        input logic [3:0] sel);
        @(posedge clk_i);
        send <= 1'b1;
        base <= b;
        bad <= m;
        @(posedge clk_i);
        send <= 1'b0;
        @(posedge clk_i);
        #1;
        if (|m && exp_tally != 16'hffff) exp_tally++;
        for (int c = 0; c < 4; c++) begin
            `CHK("rt_data", (m[c] ? 16'h0 : b + 16'(c)), rt_data[c])
            `CHK("ro_data", b + 16'(c), ro_data[c])
        end
        `CHK("ro_check", |m, ro_check)
        `CHK("ro_tally", exp_tally, tally)
        `CHK("ro_sel", sel, ro_sel)
        `CHK("ro_valid", 1'b1, ro_valid)
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #3600000;
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        send = 1'b0;
        base = 16'h0;
        bad = 4'h0;
        feat = 16'h1234;
        req = '0;
        bad_count = 0;
        num_checks = 0;
        exp_tally = 16'h0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(ilm_pkg::REG_CONTROL, 32'h0, "control");
        rd(ilm_pkg::REG_VETO, 32'h0, "veto");
        rd(8'hfc, 32'h0, "unmapped");
        xing(16'h1000, 4'h0, 4'h0);
        xing(16'h2000, 4'h5, 4'h5);
        xing(16'h3000, 4'hf, 4'hf);
        rd(ilm_pkg::REG_TALLY, 32'h2, "tally");
        rd(ilm_pkg::REG_STICKY, 32'hf, "sticky");
        rd(ilm_pkg::REG_GLOBAL, 32'h1, "global");
        wr(ilm_pkg::REG_TALLY, 32'h5);
        rd(ilm_pkg::REG_TALLY, 32'h2, "tally_ro");
        wr(ilm_pkg::REG_CLEAR, 32'h1);
        exp_tally = 16'h0;
        rd(ilm_pkg::REG_TALLY, 32'h0, "tally_clr");
        rd(ilm_pkg::REG_STICKY, 32'h0, "sticky_clr");
        rd(ilm_pkg::REG_GLOBAL, 32'h0, "global_clr");
        rd(ilm_pkg::REG_CHECK, 32'h0, "check_clr");
        // clear lands in the cycle the error is counted
        @(posedge clk_i);
        send <= 1'b1;
        bad <= 4'h2;
        @(posedge clk_i);
        send <= 1'b0;
        req <= '{addr: ilm_pkg::REG_CLEAR, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
        rd(ilm_pkg::REG_TALLY, 32'h1, "tally_race");
        rd(ilm_pkg::REG_STICKY, 32'h2, "sticky_race");
        exp_tally = 16'h1;
        wr(ilm_pkg::REG_VETO, 32'h3);
        rd(ilm_pkg::REG_VETO, 32'h3, "veto_rw");
        xing(16'h4000, 4'h1, 4'h1);
        xing(16'h4100, 4'h1, 4'h0);
        xing(16'h4200, 4'h1, 4'h1);
        wr(ilm_pkg::REG_VETO, 32'h2);
        xing(16'h4300, 4'h1, 4'h1);
        xing(16'h4400, 4'h1, 4'h1);
        wr(ilm_pkg::REG_VETO, 32'h0);
        wr(ilm_pkg::REG_CONTROL, 32'h4);
        rd(ilm_pkg::REG_CONTROL, 32'h4, "control_rw");
        xing(16'h5000, 4'h0, 4'hf);
        `CHK("rt_out_live", feat, rt_out)
        // load four input memories and the output memory
        for (int s = 0; s < 5; s++) begin
            wr(ilm_pkg::REG_MEMADDR, 32'(s) << 8);
            for (int i = 0; i < 256; i++) begin
                wr(ilm_pkg::REG_MEMDATA, 32'(s * 4096 + i));
            end
        end
        rd(ilm_pkg::REG_MEMADDR, 32'h400, "memaddr");
        wr(ilm_pkg::REG_CONTROL, 32'h3);
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_i);
            send <= (i == 10);
            bad <= 4'hf;
            #1;
            w0 = rt_data[0];
            `CHK("pb_step", {8'h00, 8'(i + 3)}, w0)
            for (int c = 1; c < 4; c++) begin
                `CHK("pb_chan", w0 + 16'(c * 4096), rt_data[c])
            end
            `CHK("pb_out", w0 + 16'h4000, rt_out)
            `CHK("pb_sel", 4'h0, ro_sel)
            `CHK("pb_valid", 1'b1, rt_valid)
        end
        wr(ilm_pkg::REG_CONTROL, 32'h1);
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("pb_no_out", feat, rt_out)
        wr(ilm_pkg::REG_CONTROL, 32'h0);
        // an error in every cycle drives the tally to its ceiling
        @(posedge clk_i);
        send <= 1'b1;
        bad <= 4'h1;
        repeat (65540) @(posedge clk_i);
        rd(ilm_pkg::REG_CHECK, 32'h1, "check_set");
        rd(ilm_pkg::REG_TALLY, 32'hffff, "tally_sat");
        @(posedge clk_i);
        send <= 1'b0;
        rd(ilm_pkg::REG_GLOBAL, 32'h1, "global_set");
        report_and_stop();
    end
endmodule // input_link_error_monitor_playback_tb
